// ### bench/mapc_mem_model.sv
// behavioural system-bus memory facing the port core
module mapc_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic        barrier_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [7:0]  dly_in,
  input  wire logic [31:0] err_addr_in,
  output logic             ready_out,
  output logic             err_out,
  output logic [31:0]      rdata_out,
  output int               acc_cnt_out,
  output logic [31:0]      last_addr_out,
  output logic             last_bar_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [16];
  logic [31:0] last_r;
  logic [7:0]  wait_r;
  assign ready_out = req_in && (wait_r >= dly_in);
  assign err_out   = ready_out && (addr_in == err_addr_in);
  // idle bus shows the inverse of the last word so stale data never passes
  assign rdata_out = ready_out ? mem[addr_in[5:2]] : ~last_r;
  // count completed accesses for the bench
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_r <= 8'h00;
      last_r <= 32'h0000_0000;
      acc_cnt_out <= 0;
      last_addr_out <= 32'h0000_0000;
      last_bar_out <= 1'b0;
    end else if (ready_out) begin
      wait_r <= 8'h00;
      acc_cnt_out <= acc_cnt_out + 1;
      last_addr_out <= addr_in;
      last_bar_out <= barrier_in;
      last_r <= rdata_out;
      if (write_in) mem[addr_in[5:2]] <= wdata_in;
    end else begin
      wait_r <= req_in ? wait_r + 8'h01 : 8'h00;
    end
  end
endmodule : mapc_mem_model

// ### bench/tb_top.sv
// self-checking bench of the memory access port core
module tb_top;
  import mapc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] BASE_V = 32'h0000_1003;
  localparam logic [31:0] ID_V   = 32'h0A5A_0001; // arbitrary value
  logic ref_clk_in, rst_b_in, wr, rd, abort, clr, permit;
  logic rvalid, busy, lerr, mreq, mwr, mbar, mready, merr, lbar;
  logic [7:0]  addr, dly;
  logic [31:0] wdata, rdata, maddr, mwdata, mrdata, eaddr, laddr;
  int          acc, n_errors, check_count, cyc;
  mapc_core #(.BASE_PTR(BASE_V), .ID_VALUE(ID_V)) dut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ap_addr_in(addr),
    .ap_wdata_in(wdata), .ap_wr_in(wr), .ap_rd_in(rd), .abort_in(abort),
    .err_clr_in(clr), .device_access_permit_in(permit),
    .ap_rdata_out(rdata), .ap_rvalid_out(rvalid), .ap_busy_out(busy),
    .latched_error_flag_out(lerr), .mem_req_out(mreq),
    .mem_write_out(mwr), .mem_barrier_out(mbar), .mem_addr_out(maddr),
    .mem_wdata_out(mwdata), .mem_ready_in(mready), .mem_err_in(merr),
    .mem_rdata_in(mrdata));
  mapc_mem_model mem (.clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .req_in(mreq), .write_in(mwr), .barrier_in(mbar), .addr_in(maddr),
    .wdata_in(mwdata), .dly_in(dly), .err_addr_in(eaddr),
    .ready_out(mready), .err_out(merr), .rdata_out(mrdata),
    .acc_cnt_out(acc), .last_addr_out(laddr), .last_bar_out(lbar));
  always #5 ref_clk_in = ~ref_clk_in;
  // hang guard, far above the few hundred cycles the tests take
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_idle();
    #1;
    repeat (300) if (busy !== 1'b0) begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask : wait_idle
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    wait_idle();
  endtask : put
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    repeat (300) if (rvalid !== 1'b1) begin
      @(posedge ref_clk_in);
      #1;
    end
    d = rdata;
  endtask : get
  task automatic t_regs();
    logic [31:0] d;
    int a0 = acc;
    put(OFF_CSW, 32'h0000_0000);
    put(OFF_TAR, 32'h0000_0040);
    get(OFF_TAR, d); chk(d, 32'h0000_0040, "tar");
    get(OFF_CSW, d); chk(d, 32'h0000_0042, "csw");
    get(OFF_CFG, d); chk(d, CFG_VAL, "cfg");
    get(OFF_BASE, d); chk(d, BASE_V, "base");
    get(OFF_IDR, d); chk(d, ID_V, "id");
    chk(acc, a0, "register access reached memory");
  endtask : t_regs
  task automatic t_drw();
    logic [31:0] d;
    dly <= 8'h05;
    put(OFF_TAR, 32'h0000_0024);
    put(OFF_DRW, 32'hCAFE_0001);
    chk(laddr, 32'h0000_0024, "write address");
    get(OFF_DRW, d); chk(d, 32'hCAFE_0001, "read data");
  endtask : t_drw
  task automatic t_bank();
    logic [31:0] d;
    put(OFF_TAR, 32'h0000_004B);
    for (int w = 0; w < 4; w++) begin
      put(OFF_BD0 + 8'(4 * w), 32'hB000_0000 + w);
      chk(laddr, 32'h0000_0040 + 4 * w, "window address");
      get(OFF_BD0 + 8'(4 * w), d);
      chk(d, 32'hB000_0000 + w, "window");
    end
  endtask : t_bank
  task automatic t_inc();
    logic [31:0] d;
    int a0;
    put(OFF_CSW, 32'h0000_0010);
    put(OFF_TAR, 32'h0000_0008);
    put(OFF_DRW, 32'h0000_0001);
    get(OFF_TAR, d); chk(d, 32'h0000_000C, "increment");
    eaddr <= 32'h0000_000C;
    put(OFF_TCNT, 32'h0000_0003);
    a0 = acc;
    put(OFF_DRW, 32'h0000_0002);
    chk(acc - a0, 1, "accesses after error");
    get(OFF_TAR, d); chk(d, 32'h0000_000C, "no step on error");
    eaddr <= 32'hFFFF_FFF0;
    put(OFF_TCNT, 32'h0000_0002);
    a0 = acc;
    put(OFF_DRW, 32'h0000_0003);
    chk(acc - a0, 3, "counted accesses");
    put(OFF_CSW, 32'h0000_0000);
  endtask : t_inc
  task automatic t_abort();
    logic [31:0] d;
    int a0 = acc;
    dly <= 8'hC8;
    @(posedge ref_clk_in);
    addr <= OFF_DRW;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    repeat (5) @(posedge ref_clk_in);
    chk(busy, 1'b1, "busy while stalled");
    abort <= 1'b1;
    @(posedge ref_clk_in);
    abort <= 1'b0;
    #1;
    chk({busy, rvalid}, 2'b01, "abort end");
    chk(acc, a0, "aborted access completed");
    dly <= 8'h02;
    get(OFF_TAR, d);
    chk(d, 32'h0000_0018, "no step on abort");
  endtask : t_abort
  task automatic t_permit();
    logic [31:0] d;
    int a0;
    put(OFF_TCNT, 32'h0000_0001);
    a0 = acc;
    put(OFF_MBT, 32'h0000_0000);
    chk({lbar, 31'(acc - a0)}, 32'h8000_0001, "barrier access");
    permit <= 1'b0;
    a0 = acc;
    get(OFF_CSW, d); chk(d[6], 1'b0, "flag low");
    put(OFF_BD0, 32'h0000_0005);
    chk(lerr, 1'b1, "latched error");
    get(OFF_DRW, d);
    chk(acc, a0, "access while not permitted");
    chk(d, 32'h0000_0000, "refused read data");
    @(posedge ref_clk_in);
    clr <= 1'b1;
    @(posedge ref_clk_in);
    clr <= 1'b0;
    permit <= 1'b1;
    #1;
    chk(lerr, 1'b0, "error cleared");
  endtask : t_permit
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // reset for six cycles, then run every scenario in turn
  initial begin
    {ref_clk_in, rst_b_in, wr, rd, abort, clr} = 6'h00;
    {permit, addr, wdata} = {1'b1, 8'h00, 32'h0000_0000};
    {dly, eaddr} = {8'h02, 32'hFFFF_FFF0};
    repeat (6) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_drw();
    t_bank();
    t_inc();
    t_abort();
    t_permit();
    report_and_stop();
  end
endmodule : tb_top

// ### design/mapc_addr_gen.sv
// memory address former for the transfer and banked windows
module mapc_addr_gen
  import mapc_pkg::*;
(
  mapc_addr_if.gen a
);
  // windows index four consecutive words from the aligned base
  // RQ5 low bits from window index, tar[3:0] dropped
  assign a.addr = a.bank ? {a.transfer_address[31:4], a.win, 2'b00} : a.transfer_address;
endmodule : mapc_addr_gen

// ### design/mapc_addr_if.sv
// address forming signals between the core and its address generator
interface mapc_addr_if;
  logic [31:0] transfer_address;
  logic [1:0]  win;
  logic        bank;
  logic [31:0] addr;
  modport gen  (input transfer_address, input win, input bank, output addr);
  modport user (output transfer_address, output win, output bank, input addr);
endinterface : mapc_addr_if

// ### design/mapc_core.sv
// memory access port core: port registers to system bus bridge
// Behaviour
// RQ1: status, address, config, base and identity accesses never touch memory
// RQ2: data word write starts a memory write at the transfer address
// RQ3: data word read starts memory read; value returned once it finishes
// RQ4: banked windows reach four words from aligned base plus 0,4,8,C
// RQ5: low four address bits ignored for windows; index gives bits 3:2
// RQ6: barrier register access starts a memory access
// RQ7: large-data option with oversize transfers skips some data accesses
// RQ8: nonzero transaction counter makes one access issue several memory ops
// RQ9: transaction ends on all success, an error, or abort
// RQ10: an error response abandons the remaining accesses of the transaction
// RQ11: counted sequences only on the data word and banked windows
// RQ12: device access permit input gates all memory transactions
// RQ13: flag in status word shows the live permit level
// RQ14: permit low: data accesses set latched error, no transaction
// RQ15: without permit input the flag reads as one
// RQ16: base pointer holds the debug component or table address
// RQ17: debugger treats each 4KB block as a register file
// RQ18: multi-component system behind the port provides an id table
// RQ19: auto-increment only after successful data word access, off or single
// RQ20: data accesses stall with no cycle limit until memory completes
// RQ21: register index decoded; written controls held until rewritten
module mapc_core
  import mapc_pkg::*;
#(
  parameter bit          HAS_PERMIT = 1'b1,
  parameter bit          HAS_LARGE  = 1'b0,
  // RQ18 base may point at an id table when several components sit behind
  parameter logic [31:0] BASE_PTR   = 32'h0000_0003,
  parameter logic [31:0] ID_VALUE   = 32'h1234_5678  // arbitrary value
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  ap_addr_in,
  input  wire logic [31:0] ap_wdata_in,
  input  wire logic        ap_wr_in,
  input  wire logic        ap_rd_in,
  input  wire logic        abort_in,
  input  wire logic        err_clr_in,
  input  wire logic        device_access_permit_in,
  output logic [31:0]      ap_rdata_out,
  output logic             ap_rvalid_out,
  output logic             ap_busy_out,
  output logic             latched_error_flag_out,
  output logic             mem_req_out,
  output logic             mem_write_out,
  output logic             mem_barrier_out,
  output logic [31:0]      mem_addr_out,
  output logic [31:0]      mem_wdata_out,
  input  wire logic        mem_ready_in,
  input  wire logic        mem_err_in,
  input  wire logic [31:0] mem_rdata_in
);
  mapc_state_type state_r, state_nxt;
  logic [31:0] tar_r, addr_r, wdata_r, rdata_r;
  logic [15:0] tcnt_r;
  logic [1:0]  inc_r;
  logic        write_r, drw_r, bar_r, rvalid_r, sticky_r;

  // address forming lives in its own leaf
  mapc_addr_if aif();
  mapc_addr_gen u_addr (.a(aif));
  assign aif.transfer_address  = tar_r;
  assign aif.win  = ap_addr_in[3:2];
  assign aif.bank = mapc_is_bank(ap_addr_in);

  // access decode
  wire       idle      = (state_r == S_IDLE);
  wire       acc       = (ap_wr_in | ap_rd_in) & idle;
  wire       is_data   = mapc_is_data(ap_addr_in);
  wire       is_mbt    = (ap_addr_in == OFF_MBT);
  // RQ15 flag tie
  wire       dev_flag  = HAS_PERMIT ? device_access_permit_in : 1'b1;
  // RQ7 large skip: only word size exists, so never taken here
  wire       large_skip = HAS_LARGE & (SIZE_WORD > SIZE_WORD);
  // RQ12 permit gate
  wire       mem_ok    = dev_flag & ~large_skip;
  // RQ1 memory start decode
  wire       start     = acc & (is_data | is_mbt) & mem_ok;
  // RQ14 refused data access
  wire       refuse    = acc & is_data & ~dev_flag;
  wire       done_ok   = ~idle & mem_ready_in & ~mem_err_in;
  wire       done_err  = ~idle & mem_ready_in & mem_err_in;
  // RQ8 more accesses pending (barrier accesses excluded through bar_r)
  wire       more      = done_ok & ~bar_r & (tcnt_r != 16'h0000);
  // RQ19 step only on success of the data word
  wire       step      = done_ok & drw_r & (inc_r == INC_SINGLE);
  wire       finish    = (done_ok & ~more) | done_err | (~idle & abort_in);

  // RQ13 status word image
  wire [31:0] csw_img = (32'(SIZE_WORD) << CSW_SIZE_LO)
                      | (32'(inc_r) << CSW_INC_LO)
                      | (32'(dev_flag) << CSW_FLAG_BIT);

  // RQ21 register read selection
  logic [31:0] reg_rd;
  always_comb begin
    unique case (ap_addr_in)
      OFF_CSW:  reg_rd = csw_img;
      OFF_TAR:  reg_rd = tar_r;
      OFF_TCNT: reg_rd = {16'h0000, tcnt_r};
      OFF_CFG:  reg_rd = CFG_VAL;
      // RQ16 base pointer
      OFF_BASE: reg_rd = BASE_PTR;
      OFF_IDR:  reg_rd = ID_VALUE;
      default:  reg_rd = 32'h0000_0000;
    endcase
  end

  // RQ9 transaction state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (start) state_nxt = S_BUSY;
      // RQ20 stall without limit
      S_BUSY: if (finish) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) state_r <= S_IDLE;
    else           state_r <= state_nxt;
  end

  // RQ21 control registers; writes land only while idle
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inc_r  <= INC_OFF;
      tar_r  <= TAR_RST;
      tcnt_r <= TCNT_RST;
    end else begin
      // packed mode unsupported, so 2 and 3 fall back to off
      if (acc & ap_wr_in & (ap_addr_in == OFF_CSW))
        inc_r <= (ap_wdata_in[CSW_INC_LO+:2] == INC_SINGLE) ? INC_SINGLE
                                                            : INC_OFF;
      if (acc & ap_wr_in & (ap_addr_in == OFF_TAR))
        tar_r <= ap_wdata_in;
      // RQ19 address advance
      else if (step)
        tar_r <= tar_r + WORD_STEP;
      if (acc & ap_wr_in & (ap_addr_in == OFF_TCNT))
        tcnt_r <= ap_wdata_in[15:0];
      // RQ8 one count per extra access
      else if (more)
        tcnt_r <= tcnt_r - 16'h0001;
    end
  end

  // RQ2 transfer launch: address, direction and data captured together
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_r  <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      write_r <= 1'b0;
      drw_r   <= 1'b0;
      bar_r   <= 1'b0;
    end else if (start) begin
      // RQ4 banked address from the leaf
      addr_r  <= aif.addr;
      wdata_r <= ap_wdata_in;
      write_r <= ap_wr_in;
      drw_r   <= (ap_addr_in == OFF_DRW);
      // RQ11 barrier never counted
      bar_r   <= is_mbt;
    end else if (step) begin
      addr_r  <= addr_r + WORD_STEP;
    end
  end

  // RQ3 read answer: register reads next cycle, memory reads at finish
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      if (acc & ap_rd_in & ~start) begin
        rdata_r  <= (is_data | is_mbt) ? 32'h0000_0000 : reg_rd;
        rvalid_r <= 1'b1;
      end else if (finish & ~write_r) begin
        rdata_r  <= done_ok ? mem_rdata_in : 32'h0000_0000;
        rvalid_r <= 1'b1;
      end
    end
  end

  // RQ14 latched error; a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)                 sticky_r <= 1'b0;
    // RQ10 error abandons the rest
    else if (refuse | done_err)    sticky_r <= 1'b1;
    else if (err_clr_in)           sticky_r <= 1'b0;
  end

  // outputs
  assign ap_rdata_out           = rdata_r;
  assign ap_rvalid_out          = rvalid_r;
  assign ap_busy_out            = ~idle;
  assign latched_error_flag_out = sticky_r;
  // RQ6 barrier qualifier on the request
  assign mem_req_out            = ~idle & ~abort_in;
  assign mem_write_out          = write_r;
  assign mem_barrier_out        = bar_r;
  assign mem_addr_out           = addr_r;
  assign mem_wdata_out          = wdata_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  wire data_only = (ap_addr_in == OFF_CSW) || (ap_addr_in == OFF_TAR)
                || (ap_addr_in == OFF_CFG) || (ap_addr_in == OFF_BASE)
                || (ap_addr_in == OFF_IDR);

  no_mem_cfg_a: assert property ( // RQ1
    acc & data_only |=> !mem_req_out)
    else $error("register access started a memory request");

  drw_write_a: assert property ( // RQ2
    acc & ap_wr_in & (ap_addr_in == OFF_DRW) & dev_flag
    |=> mem_req_out & mem_write_out & (mem_addr_out == $past(tar_r))
        & (mem_wdata_out == $past(ap_wdata_in)))
    else $error("data word write did not launch at transfer address");

  read_return_a: assert property ( // RQ3
    done_ok & ~more & ~write_r
    |=> ap_rvalid_out & (ap_rdata_out == $past(mem_rdata_in)))
    else $error("memory read value not returned");

  bank_addr_a: assert property ( // RQ4
    start & aif.bank
    |=> mem_addr_out == {$past(tar_r[31:4]), $past(ap_addr_in[3:2]), 2'b00})
    else $error("banked window address wrong");

  mbt_start_a: assert property ( // RQ6
    acc & is_mbt & dev_flag |=> mem_req_out & mem_barrier_out)
    else $error("barrier access did not start");

  err_abandon_a: assert property ( // RQ10
    done_err |=> !ap_busy_out & latched_error_flag_out
                 & (tar_r == $past(tar_r)))
    else $error("error did not end the transaction");

  abort_end_a: assert property ( // RQ9
    ~idle & abort_in |=> !ap_busy_out & (tar_r == $past(tar_r)))
    else $error("abort did not end the transaction");

  permit_err_a: assert property ( // RQ14
    acc & is_data & ~dev_flag |=> latched_error_flag_out & !mem_req_out)
    else $error("refused access did not latch error");

  flag_read_a: assert property ( // RQ13
    acc & ap_rd_in & (ap_addr_in == OFF_CSW)
    |=> ap_rdata_out[CSW_FLAG_BIT] == $past(dev_flag))
    else $error("status flag does not match permit");

  tar_step_a: assert property ( // RQ19
    step |=> tar_r == $past(tar_r) + WORD_STEP)
    else $error("transfer address not advanced");

  count_more_a: assert property ( // RQ8
    more |=> ap_busy_out & (tcnt_r == $past(tcnt_r) - 16'h0001))
    else $error("counted sequence stopped early");

  c_write_c: cover property (start & ap_wr_in ##[1:20] done_ok);
  c_read_c:  cover property (start & ap_rd_in ##[1:20] ap_rvalid_out);
  c_err_c:   cover property (done_err);
  c_cnt_c:   cover property (more ##[1:20] finish);
endmodule : mapc_core

// ### design/mapc_pkg.sv
// shared constants and types of the memory access port core
package mapc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CSW   = 8'h00;
  localparam logic [7:0] OFF_TAR   = 8'h04;
  localparam logic [7:0] OFF_TCNT  = 8'h08;
  localparam logic [7:0] OFF_DRW   = 8'h0C;
  localparam logic [7:0] OFF_BD0   = 8'h10;
  localparam logic [7:0] OFF_MBT   = 8'h20;
  localparam logic [7:0] OFF_CFG   = 8'hF4;
  localparam logic [7:0] OFF_BASE  = 8'hF8;
  localparam logic [7:0] OFF_IDR   = 8'hFC;
  // control/status word layout
  localparam int         CSW_SIZE_LO  = 0;
  localparam int         CSW_INC_LO   = 4;
  localparam int         CSW_FLAG_BIT = 6;
  localparam logic [2:0] SIZE_WORD    = 3'h2;
  localparam logic [1:0] INC_OFF      = 2'h0;
  localparam logic [1:0] INC_SINGLE   = 2'h1;
  // reset values and steps
  localparam logic [31:0] TAR_RST   = 32'h0000_0000;
  localparam logic [15:0] TCNT_RST  = 16'h0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] CFG_VAL   = 32'h0000_0000;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } mapc_state_type;

  // data window decode: read/write word or one of the banked windows
  function automatic logic mapc_is_data(input logic [7:0] off);
    mapc_is_data = (off == OFF_DRW) || (off[7:4] == OFF_BD0[7:4]);
  endfunction : mapc_is_data

  function automatic logic mapc_is_bank(input logic [7:0] off);
    mapc_is_bank = (off[7:4] == OFF_BD0[7:4]);
  endfunction : mapc_is_bank
endpackage : mapc_pkg
